// ==== design/blc_pkg.sv ====
`default_nettype none

package blc_pkg;

    // ----------------------------------------------------------------
    // Register map (register indices; byte address is index times four)
    // ----------------------------------------------------------------
    localparam int DATA_W = 12;
    localparam logic [11:0] CTL_IDX = 12'h140;
    localparam logic [11:0] STAT_IDX = 12'h141;
    localparam logic [11:0] FMT_IDX = 12'h150;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SYNC_LSB = 0;
    localparam int MARKER_BIT = 2;
    localparam int WIN1_BIT = 5;
    localparam int WIN2_BIT = 6;
    localparam int DEC_BIT = 10;
    localparam int TM_BIT = 11;
    localparam int NUM_FLAGS = 4;
    localparam int FLAG_POS [NUM_FLAGS] = '{WIN1_BIT, WIN2_BIT, DEC_BIT, TM_BIT};
    localparam int FLAG_WIN1 = 0;
    localparam int FLAG_WIN2 = 1;
    localparam int FLAG_DEC = 2;
    localparam int FLAG_TM = 3;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic MARKER_RST = 1'h0;
    localparam logic FLAG_RST = 1'h1;
    localparam logic [11:0] FMT_RST = 12'h010;
    localparam logic [1:0] SYNC_TRACK = 2'h0;
    localparam logic [1:0] SYNC_FREE = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SEL_NONE, SEL_CTL, SEL_STAT, SEL_FMT} blc_sel_t;

    typedef struct packed {
        logic marker;
        logic [1:0] sync;
    } blc_mode_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic [2:0] awprot;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic [2:0] arprot;
        logic rready;
    } blc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } blc_axi_rsp_t;

    function automatic blc_sel_t blc_decode(input logic [31:0] addr);
        blc_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:14] == 18'h0) begin
            if (addr[13:2] == CTL_IDX) sel = SEL_CTL;
            else if (addr[13:2] == STAT_IDX) sel = SEL_STAT;
            else if (addr[13:2] == FMT_IDX) sel = SEL_FMT;
        end
        return sel;
    endfunction : blc_decode

    function automatic logic [11:0] blc_lane_mask(input logic [3:0] strb);
        return {{4{strb[1]}}, {8{strb[0]}}};
    endfunction : blc_lane_mask

    function automatic logic [11:0] blc_merge(input logic [11:0] old_v,
                                              input logic [11:0] new_v,
                                              input logic [11:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction : blc_merge

endpackage : blc_pkg

`default_nettype wire

// ==== design/blc_axil_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

module blc_axil_slave
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AXI4-Lite
    input wire blc_axi_req_t axi_req_in,
    output var blc_axi_rsp_t axi_rsp_out,
    // Register side
    output logic wr_en_out,
    output var blc_sel_t wr_sel_out,
    output logic [11:0] wr_data_out,
    output logic [11:0] wr_mask_out,
    output var blc_sel_t rd_sel_out,
    input wire logic [11:0] rd_data_in
);

    typedef struct packed {
        logic aw_full;
        logic [31:0] aw_addr;
        logic w_full;
        logic [11:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [11:0] rdata;
        logic [1:0] rresp;
    } blc_slv_state_t;

    blc_slv_state_t q, d;
    logic awready, wready, arready, do_wr;

    assign wr_sel_out = blc_decode(q.aw_addr);
    assign rd_sel_out = blc_decode(axi_req_in.araddr);
    assign wr_data_out = q.w_data;
    assign wr_mask_out = blc_lane_mask(q.w_strb);
    assign wr_en_out = do_wr;

    always_comb begin
        d = q;
        // Address and data are parked until both have arrived
        awready = !q.aw_full && !q.bvalid;
        wready = !q.w_full && !q.bvalid;
        arready = !q.rvalid;
        do_wr = q.aw_full && q.w_full && !q.bvalid;
        if (axi_req_in.awvalid && awready) begin
            d.aw_full = 1'h1;
            d.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && wready) begin
            d.w_full = 1'h1;
            d.w_data = axi_req_in.wdata[11:0];
            d.w_strb = axi_req_in.wstrb;
        end
        if (do_wr) begin
            d.aw_full = 1'h0;
            d.w_full = 1'h0;
            d.bvalid = 1'h1;
            // The status word refuses writes
            d.bresp = (wr_sel_out == SEL_CTL || wr_sel_out == SEL_FMT) ? RESP_OKAY
                                                                        : RESP_SLVERR;
        end
        if (q.bvalid && axi_req_in.bready) d.bvalid = 1'h0;
        if (axi_req_in.arvalid && arready) begin
            d.rvalid = 1'h1;
            d.rdata = rd_data_in;
            d.rresp = (rd_sel_out == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (q.rvalid && axi_req_in.rready) d.rvalid = 1'h0;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) q <= '0;
        else q <= d;
    end

    always_comb begin
        axi_rsp_out = '0;
        axi_rsp_out.awready = awready;
        axi_rsp_out.wready = wready;
        axi_rsp_out.bvalid = q.bvalid;
        axi_rsp_out.bresp = q.bresp;
        axi_rsp_out.arready = arready;
        axi_rsp_out.rvalid = q.rvalid;
        axi_rsp_out.rdata = {20'h0, q.rdata};
        axi_rsp_out.rresp = q.rresp;
    end

endmodule : blc_axil_slave

`default_nettype wire

// ==== design/blc_latch_flag.sv ====
`timescale 1ns/1ps
`default_nettype none

module blc_latch_flag
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Software set and commit pulse
    input wire logic set_in,
    output logic flag_out
);

    typedef struct packed {
        logic flag;
    } blc_flag_state_t;

    blc_flag_state_t q, d;

    // Flag lives one cycle, then clears itself; a set in the clearing
    // cycle wins, so back-to-back latch requests are never dropped.
    always_comb begin
        d = q;
        d.flag = set_in;
    end

    // Reset value is one so the first cycle commits the defaults
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) q <= '{flag: FLAG_RST};
        else q <= d;
    end

    assign flag_out = q.flag;

endmodule : blc_latch_flag

`default_nettype wire

// ==== design/blc_top.sv ====
// Notes on behaviour
// - Control word is 12 bits, writable and readable
// - Selector 00: syncs track incoming video
// - Selector 10: syncs run free
// - Marker length: window size or programmable
// - Timing selection commits on self-clearing flag
// - Window one flag commits, then self-clears
// - Window two flag commits, then self-clears
// - Decimation count commits on self-clearing flag
// - Status word is read-only working state
// - Status bit two shows marker mode in use
// - Reset: modes zero, all four flags one
`timescale 1ns/1ps
`default_nettype none

module blc_top
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AXI4-Lite register bus
    input wire blc_axi_req_t axi_req_in,
    output var blc_axi_rsp_t axi_rsp_out,
    // Working timing state
    output logic [1:0] sync_mode_out,
    output logic track_input_out,
    output logic free_run_out,
    output logic marker_programmable_out,
    // Commit pulses
    output logic timing_commit_out,
    output logic window_one_commit_out,
    output logic window_two_commit_out,
    output logic decim_commit_out,
    // Formatter selection
    output logic [11:0] format_select_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        blc_mode_t shadow;
        blc_mode_t work;
        logic [11:0] fmt;
    } blc_top_state_t;

    blc_top_state_t q, d;

    logic wr_en;
    blc_sel_t wr_sel;
    logic [11:0] wr_data;
    logic [11:0] wr_mask;
    blc_sel_t rd_sel;
    logic [11:0] rd_data;
    logic wr_ctl;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flags;
    logic [11:0] ctl_word;
    logic [11:0] stat_word;
    logic [11:0] ctl_merged;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    blc_axil_slave i_blc_axil_slave (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .axi_req_in(axi_req_in),
        .axi_rsp_out(axi_rsp_out),
        .wr_en_out(wr_en),
        .wr_sel_out(wr_sel),
        .wr_data_out(wr_data),
        .wr_mask_out(wr_mask),
        .rd_sel_out(rd_sel),
        .rd_data_in(rd_data)
    );

    assign wr_ctl = wr_en && (wr_sel == SEL_CTL);

    // ----------------------------------------------------------------
    // Latch flags
    // ----------------------------------------------------------------
    // A flag is set only by a one in its own bit under an enabled lane
    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            assign flag_set[i] = wr_ctl && wr_data[FLAG_POS[i]] && wr_mask[FLAG_POS[i]];
            blc_latch_flag i_blc_latch_flag (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .set_in(flag_set[i]),
                .flag_out(flags[i])
            );
        end
    endgenerate

    assign timing_commit_out = flags[FLAG_TM];
    assign window_one_commit_out = flags[FLAG_WIN1];
    assign window_two_commit_out = flags[FLAG_WIN2];
    assign decim_commit_out = flags[FLAG_DEC];

    // ----------------------------------------------------------------
    // Readback words
    // ----------------------------------------------------------------
    // Reserved positions are not stored and read as zero, so stray
    // software writes there cannot reach the working state.
    always_comb begin
        ctl_word = 12'h000;
        ctl_word[SYNC_LSB+:2] = q.shadow.sync;
        ctl_word[MARKER_BIT] = q.shadow.marker;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            ctl_word[FLAG_POS[i]] = flags[i];
        end
    end

    always_comb begin
        stat_word = 12'h000;
        stat_word[SYNC_LSB+:2] = q.work.sync;
        stat_word[MARKER_BIT] = q.work.marker;
    end

    always_comb begin
        unique case (rd_sel)
            SEL_CTL: rd_data = ctl_word;
            SEL_STAT: rd_data = stat_word;
            SEL_FMT: rd_data = 12'h000;
            SEL_NONE: rd_data = 12'h000;
        endcase
    end

    assign ctl_merged = blc_merge(ctl_word, wr_data, wr_mask);

    // ----------------------------------------------------------------
    // Shadow and working settings
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        if (wr_ctl) begin
            d.shadow.sync = ctl_merged[SYNC_LSB+:2];
            d.shadow.marker = ctl_merged[MARKER_BIT];
        end
        if (wr_en && wr_sel == SEL_FMT) begin
            d.fmt = blc_merge(q.fmt, wr_data, wr_mask);
        end
        // Working copy moves only on the timing latch; the marker mode
        // rides with it so sync and marker never disagree mid-field.
        if (flags[FLAG_TM]) begin
            d.work = q.shadow;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q.shadow <= '{marker: MARKER_RST, sync: SYNC_RST};
            q.work <= '{marker: MARKER_RST, sync: SYNC_RST};
            q.fmt <= FMT_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Codes 01 and 11 leave both sync sources deasserted
    assign sync_mode_out = q.work.sync;
    assign track_input_out = (q.work.sync == SYNC_TRACK);
    assign free_run_out = (q.work.sync == SYNC_FREE);
    assign marker_programmable_out = q.work.marker;
    assign format_select_out = q.fmt;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic first_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) first_q <= 1'h1;
        else first_q <= 1'h0;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_ctl_write;
        wr_ctl && wr_mask[0] |=> q.shadow.sync == $past(wr_data[1:0])
            && ctl_word[1:0] == $past(wr_data[1:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("ctl write lost");

    property p_track;
        track_input_out |-> stat_word[1:0] == 2'h0 && !free_run_out;
    endproperty
    a_track: assert property (p_track) else $error("track mode mismatch");

    property p_free;
        $changed(free_run_out) |-> $past(flags[FLAG_TM]);
    endproperty
    a_free: assert property (p_free) else $error("free run moved without latch");

    property p_marker;
        $changed(marker_programmable_out) |-> $past(flags[FLAG_TM])
            && marker_programmable_out == $past(q.shadow.marker);
    endproperty
    a_marker: assert property (p_marker) else $error("marker mode moved badly");

    property p_tm_clear;
        !first_q && flags[FLAG_TM] && !flag_set[FLAG_TM] |=> !flags[FLAG_TM];
    endproperty
    a_tm_clear: assert property (p_tm_clear) else $error("timing flag stuck");

    property p_win1;
        wr_ctl && wr_data[WIN1_BIT] && wr_mask[WIN1_BIT] |=> window_one_commit_out
            ##1 (!window_one_commit_out || $past(flag_set[FLAG_WIN1]));
    endproperty
    a_win1: assert property (p_win1) else $error("window one commit wrong");

    property p_win2;
        !first_q && !flag_set[FLAG_WIN2] |=> !window_two_commit_out;
    endproperty
    a_win2: assert property (p_win2) else $error("window two commit wrong");

    property p_dec;
        flag_set[FLAG_DEC] |=> decim_commit_out;
    endproperty
    a_dec: assert property (p_dec) else $error("decimation commit missing");

    property p_stat_read;
        axi_req_in.arvalid && axi_rsp_out.arready && rd_sel == SEL_STAT
            |=> axi_rsp_out.rdata[2:0] == $past(q.work) && axi_rsp_out.rdata[11:3] == 9'h0;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_stat_bit;
        stat_word[MARKER_BIT] == marker_programmable_out;
    endproperty
    a_stat_bit: assert property (p_stat_bit) else $error("status bit two wrong");

    property p_reset;
        first_q |-> flags == 4'hf && sync_mode_out == 2'h0 && !marker_programmable_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    property p_hold;
        !flags[FLAG_TM] |=> $stable(q.work);
    endproperty
    a_hold: assert property (p_hold) else $error("working state moved");

    // Flags still stand in the cycle after release, so clear checks skip it
    property p_tm_set;
        flag_set[FLAG_TM] |=> timing_commit_out;
    endproperty
    a_tm_set: assert property (p_tm_set) else $error("timing flag missing");

    property p_win1_clear;
        !first_q && !flag_set[FLAG_WIN1] |=> !window_one_commit_out;
    endproperty
    a_win1_clear: assert property (p_win1_clear) else $error("window one flag stuck");

    property p_win2_set;
        flag_set[FLAG_WIN2] |=> window_two_commit_out;
    endproperty
    a_win2_set: assert property (p_win2_set) else $error("window two flag missing");

    property p_dec_clear;
        !first_q && !flag_set[FLAG_DEC] |=> !decim_commit_out;
    endproperty
    a_dec_clear: assert property (p_dec_clear) else $error("decimation flag stuck");

    property p_commit_copy;
        flags[FLAG_TM] |=> q.work == $past(q.shadow);
    endproperty
    a_commit_copy: assert property (p_commit_copy) else $error("latch copy wrong");

    property p_marker_write;
        wr_ctl && wr_mask[MARKER_BIT] |=> q.shadow.marker == $past(wr_data[MARKER_BIT]);
    endproperty
    a_marker_write: assert property (p_marker_write) else $error("marker write lost");

    property p_free_code;
        free_run_out |-> sync_mode_out == SYNC_FREE && !track_input_out;
    endproperty
    a_free_code: assert property (p_free_code) else $error("free run code wrong");

    property p_stat_refuse;
        wr_en && wr_sel == SEL_STAT |=> axi_rsp_out.bvalid && axi_rsp_out.bresp == RESP_SLVERR
            && q.shadow == $past(q.shadow);
    endproperty
    a_stat_refuse: assert property (p_stat_refuse) else $error("status write taken");

    property p_ctl_read;
        axi_req_in.arvalid && axi_rsp_out.arready && rd_sel == SEL_CTL
            |=> axi_rsp_out.rdata[11:0] == $past(ctl_word);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

    c_free: cover property (flag_set[FLAG_TM] ##1 1'b1 ##1 free_run_out);
    c_win_both: cover property (window_one_commit_out && window_two_commit_out && !first_q);
    c_stat: cover property (rd_sel == SEL_STAT && axi_req_in.arvalid && axi_rsp_out.arready);
    c_odd_code: cover property (sync_mode_out == 2'h1 && !track_input_out && !free_run_out);
    c_refused: cover property (axi_rsp_out.bvalid && axi_rsp_out.bresp == RESP_SLVERR);

endmodule : blc_top

`default_nettype wire

// ==== tb/test_blc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_blc_top;
    import blc_pkg::*;

    // ----------------------------------------------------------------
    // Addresses, limits and design
    // ----------------------------------------------------------------
    localparam logic [31:0] CTL_ADDR = {18'h0, CTL_IDX, 2'h0};
    localparam logic [31:0] STAT_ADDR = {18'h0, STAT_IDX, 2'h0};
    localparam logic [31:0] FMT_ADDR = {18'h0, FMT_IDX, 2'h0};
    localparam logic [31:0] HOLE_ADDR = 32'h0000_0600;
    // The whole sequence needs well under a thousand cycles
    localparam int MAX_CYCLES = 5000;

    logic clk_in;
    logic rst_in;
    blc_axi_req_t axi_req;
    blc_axi_rsp_t axi_rsp;
    logic [1:0] sync_mode;
    logic track_input;
    logic free_run;
    logic marker_prog;
    logic [3:0] commit;
    logic [11:0] format_select;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int pulses [4] = '{0, 0, 0, 0};
    int snap [4] = '{0, 0, 0, 0};

    blc_top i_blc_top (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .axi_req_in(axi_req),
        .axi_rsp_out(axi_rsp),
        .sync_mode_out(sync_mode),
        .track_input_out(track_input),
        .free_run_out(free_run),
        .marker_programmable_out(marker_prog),
        .timing_commit_out(commit[FLAG_TM]),
        .window_one_commit_out(commit[FLAG_WIN1]),
        .window_two_commit_out(commit[FLAG_WIN2]),
        .decim_commit_out(commit[FLAG_DEC]),
        .format_select_out(format_select)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Counting pulse cycles shows a flag that sticks as well as one that never fires
    always @(posedge clk_in) begin
        cycles++;
        if (!rst_in) begin
            for (int i = 0; i < 4; i++) begin
                pulses[i] += commit[i];
            end
        end
        if (cycles == MAX_CYCLES) begin
            n_errors++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic axi_write(input logic [31:0] addr, input logic [11:0] data,
                             input logic [1:0] exp_resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_in);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= addr;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {20'h0, data};
        axi_req.wstrb <= 4'hf;
        while (!(aw_done && w_done)) begin
            @(posedge clk_in);
            if (!aw_done && axi_rsp.awready === 1'b1) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_done && axi_rsp.wready === 1'b1) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        do @(posedge clk_in); while (axi_rsp.bvalid !== 1'b1);
        check("bresp", 32'(exp_resp), 32'(axi_rsp.bresp));
    endtask : axi_write

    task automatic axi_read(input string what, input logic [31:0] addr,
                            input logic [11:0] exp, input logic [1:0] exp_resp);
        @(posedge clk_in);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= addr;
        do @(posedge clk_in); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        do @(posedge clk_in); while (axi_rsp.rvalid !== 1'b1);
        check(what, {20'h0, exp}, axi_rsp.rdata);
        check("rresp", 32'(exp_resp), 32'(axi_rsp.rresp));
    endtask : axi_read

    task automatic ctl_write(input logic [11:0] data, input logic [3:0] exp_pulses);
        axi_write(CTL_ADDR, data, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        #1;
        for (int i = 0; i < 4; i++) begin
            check("commit pulses", 32'(exp_pulses[i]), 32'(pulses[i] - snap[i]));
        end
        snap = pulses;
    endtask : ctl_write

    task automatic check_state(input logic [1:0] sync, input logic marker);
        check("sync mode", 32'(sync), 32'(sync_mode));
        check("track input", 32'(sync == SYNC_TRACK), 32'(track_input));
        check("free run", 32'(sync == SYNC_FREE), 32'(free_run));
        check("marker mode", 32'(marker), 32'(marker_prog));
    endtask : check_state

    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check("commit at release", 32'h0000_000f, 32'(commit));
        check_state(SYNC_RST, MARKER_RST);
        check("format select", 32'(FMT_RST), 32'(format_select));
        @(posedge clk_in);
        #1;
        check("commit after release", 32'h0, 32'(commit));
        snap = pulses;
    endtask : do_reset

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        axi_req = '0;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        do_reset();
        axi_read("control word", CTL_ADDR, 12'h000, RESP_OKAY);
        axi_read("status word", STAT_ADDR, 12'h000, RESP_OKAY);
        // Pending selector and marker mode without any flag: nothing moves
        ctl_write(12'h006, 4'h0);
        check_state(SYNC_TRACK, 1'b0);
        axi_read("control word", CTL_ADDR, 12'h006, RESP_OKAY);
        axi_read("status word", STAT_ADDR, 12'h000, RESP_OKAY);
        ctl_write(12'h806, 4'h8);
        check_state(SYNC_FREE, 1'b1);
        axi_read("status word", STAT_ADDR, 12'h006, RESP_OKAY);
        axi_read("control word", CTL_ADDR, 12'h006, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            ctl_write(12'h006 | (12'h001 << FLAG_POS[i]), 4'h1 << i);
            axi_read("control word", CTL_ADDR, 12'h006, RESP_OKAY);
        end
        // Window flag with a new selector pending must leave timing alone
        ctl_write(12'h020, 4'h1);
        check_state(SYNC_FREE, 1'b1);
        axi_read("status word", STAT_ADDR, 12'h006, RESP_OKAY);
        ctl_write(12'h800, 4'h8);
        check_state(SYNC_TRACK, 1'b0);
        axi_read("status word", STAT_ADDR, 12'h000, RESP_OKAY);
        axi_write(STAT_ADDR, 12'h006, RESP_SLVERR);
        axi_read("status word", STAT_ADDR, 12'h000, RESP_OKAY);
        check_state(SYNC_TRACK, 1'b0);
        axi_write(HOLE_ADDR, 12'h0ff, RESP_SLVERR);
        axi_read("unmapped word", HOLE_ADDR, 12'h000, RESP_SLVERR);
        axi_write(FMT_ADDR, 12'h123, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        #1;
        check("format select", 32'h0000_0123, 32'(format_select));
        // Selector code 01 commits but drives neither sync source
        ctl_write(12'h801, 4'h8);
        check_state(2'h1, 1'b0);
        // Commit free-run again, then reset in mid-run must restore defaults
        ctl_write(12'h802, 4'h8);
        check_state(SYNC_FREE, 1'b0);
        do_reset();
        axi_read("status word", STAT_ADDR, 12'h000, RESP_OKAY);
        complete_run();
    end

endmodule : test_blc_top

`default_nettype wire
